// File: rtl/linefeed_ctrl.sv
// Notes on behaviour
// - Eight line states chosen by software code
// - Reset leaves the line in open state
// - Open state: leads high-Z, supervision, audio off
// - Fault forces open state and raises alarm
// - Alarm maskable; auto open may be disabled
// - Faults: total power, foreign, thermal shutdown
// - Over temperature forces low power autonomously
// - Threshold 145 C, 200 C while ringing
// - Monitor results refresh at least 2 kHz
// - Loop voltage, loop and longitudinal current
// - Forward active: feed, audio, tip positive
// - Reverse active: feed, audio, ring positive
// - On-hook transmission feeds with matching polarity
// - Tip open: ring fed, tip high-Z
// - Ring open: tip fed, ring high-Z
// - Ringing drives both leads, optional offset
// - Diagnostics enables test resources, leads high-Z
// - Active feed in one of three regions
`timescale 1ns/1ps
module linefeed_ctrl #(
  parameter int MON_PERIOD = linefeed_pkg::MON_PERIOD_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire linefeed_pkg::lf_code_t            state_sel,
  input  wire logic                              diag_sel,
  input  wire logic                              state_wr,
  input  wire logic                              ring_offset_cfg,
  input  wire logic                              auto_open_en,
  input  wire logic                              alarm_mask,
  input  wire logic                              alarm_clr,
  input  wire linefeed_pkg::fault_s              cause_clr,
  input  wire logic                              osi_start,
  input  wire logic [linefeed_pkg::OSI_W-1:0]    osi_cycles,
  input  wire logic                              power_exceed_pin,
  input  wire logic                              foreign_fault_pin,
  input  wire logic [linefeed_pkg::TEMP_W-1:0]   die_temp_pin,
  input  wire linefeed_pkg::lead_s               lead_pin,
  input  wire logic [linefeed_pkg::MON_W-1:0]    cv_i_max,
  input  wire logic [linefeed_pkg::MON_W-1:0]    cc_i_min,
  output linefeed_pkg::lf_code_t                 lf_state,
  output logic                                   diag_active,
  output logic                                   tripped,
  output logic                                   osi_busy,
  output linefeed_pkg::drive_s                   drive,
  output logic                                   low_power,
  output linefeed_pkg::fault_s                   alarm_cause,
  output logic                                   alarm_pending,
  output logic                                   power_alarm_irq,
  output linefeed_pkg::mon_s                     mon,
  output logic                                   mon_valid,
  output linefeed_pkg::dc_region_e               dc_region
);
  import linefeed_pkg::*;

  localparam int CNT_W = $clog2(MON_PERIOD + 1);
  localparam logic [CNT_W-1:0] CNT_RELOAD = CNT_W'(MON_PERIOD - 1);
  localparam logic [TEMP_W-1:0] THR_NORMAL  = TEMP_W'(TJ_NORMAL_C);
  localparam logic [TEMP_W-1:0] THR_RINGING = TEMP_W'(TJ_RINGING_C);

  typedef enum logic [1:0] {
    CTL_RUN,
    CTL_TRIPPED,
    CTL_OSI
  } ctl_e;

  typedef struct packed {
    logic [1:0]        fpin1;
    logic [1:0]        fpin2;
    logic [TEMP_W-1:0] temp1;
    logic [TEMP_W-1:0] temp2;
    lead_s             lead1;
    lead_s             lead2;
    ctl_e              ctl;
    lf_code_t          lf;
    lf_code_t          lf_saved;
    logic              diag;
    logic              diag_saved;
    logic [OSI_W-1:0]  osi_cnt;
    drive_s            drv;
    logic              low_power;
    fault_s            cause;
    logic              pend;
    logic              irq;
    logic [CNT_W-1:0]  mon_cnt;
    mon_s              mon;
    logic              mon_valid;
    dc_region_e        region;
    logic              held_open;
    logic              in_osi;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // Magnitude of a signed sample, saturating the most negative value
  function automatic logic [MON_W-1:0] mag(
    input logic signed [MON_W-1:0] v
  );
    logic [MON_W-1:0] r;
    r = v[MON_W-1] ? MON_W'(-v) : MON_W'(v);
    if (v[MON_W-1] && r[MON_W-1]) begin
      r = {1'b0, {(MON_W-1){1'b1}}};
    end
    return r;
  endfunction

  // Active feed states share dc region tracking
  function automatic logic is_feed(input lf_code_t c);
    return (c == LF_FWD_ACT) || (c == LF_REV_ACT) ||
           (c == LF_FWD_OHT) || (c == LF_REV_OHT);
  endfunction

  // Scratch values of the next-state logic
  logic [TEMP_W-1:0]     thr;
  fault_s                fault_now;
  logic                  fault_any;
  logic                  trip;
  logic signed [MON_W:0] dv;
  logic signed [MON_W:0] di;
  logic signed [MON_W:0] si;
  logic [MON_W-1:0]      imag;

  always_comb begin
    nxt_st = st_ff;
    // Second stage only read by logic
    nxt_st.fpin1 = {power_exceed_pin, foreign_fault_pin};
    nxt_st.fpin2 = st_ff.fpin1;
    // Multi-bit words assume slow pins; no coherence guard
    nxt_st.temp1 = die_temp_pin;
    nxt_st.temp2 = st_ff.temp1;
    nxt_st.lead1 = lead_pin;
    nxt_st.lead2 = st_ff.lead1;

    thr = (st_ff.lf == LF_RINGING) ? THR_RINGING : THR_NORMAL;

    // A pin pulse shorter than a clock can be missed
    // three fault sources
    fault_now.power   = st_ff.fpin2[1];
    fault_now.foreign = st_ff.fpin2[0];
    fault_now.thermal = st_ff.temp2 > thr;
    fault_any = fault_now.power | fault_now.foreign | fault_now.thermal;

    trip = fault_any && auto_open_en;

    nxt_st.low_power = fault_now.thermal;

    // sticky causes, set wins over clear
    nxt_st.cause = (st_ff.cause & ~cause_clr) | fault_now;
    nxt_st.pend  = (st_ff.pend & ~alarm_clr) | fault_any;
    nxt_st.irq   = nxt_st.pend & ~alarm_mask;

    unique case (st_ff.ctl)
      CTL_RUN: begin
        if (trip) begin
          nxt_st.ctl  = CTL_TRIPPED;
          nxt_st.lf   = LF_OPEN;
          nxt_st.diag = 1'b0;
        end else if (osi_start && osi_cycles != '0) begin
          // Open switch interval, then back to prior state
          nxt_st.ctl        = CTL_OSI;
          nxt_st.lf_saved   = st_ff.lf;
          nxt_st.diag_saved = st_ff.diag;
          nxt_st.lf         = LF_OPEN;
          nxt_st.diag       = 1'b0;
          nxt_st.osi_cnt    = osi_cycles;
        end else if (state_wr) begin
          nxt_st.lf   = state_sel;
          nxt_st.diag = diag_sel;
        end
      end
      CTL_OSI: begin
        // A trip in the interval is never undone by its end
        if (trip) begin
          nxt_st.ctl = CTL_TRIPPED;
        end else if (st_ff.osi_cnt == OSI_W'(1)) begin
          nxt_st.ctl  = CTL_RUN;
          nxt_st.lf   = st_ff.lf_saved;
          nxt_st.diag = st_ff.diag_saved;
        end
        nxt_st.osi_cnt = st_ff.osi_cnt - OSI_W'(1);
      end
      CTL_TRIPPED: begin
        // Held open until software rewrites with faults gone
        nxt_st.lf   = LF_OPEN;
        nxt_st.diag = 1'b0;
        if (state_wr && !fault_any) begin
          nxt_st.ctl  = CTL_RUN;
          nxt_st.lf   = state_sel;
          nxt_st.diag = diag_sel;
        end
      end
      default: begin
        nxt_st.ctl = CTL_TRIPPED;
        nxt_st.lf  = LF_OPEN;
      end
    endcase

    // everything off by default, the open state
    nxt_st.drv = '0;
    unique case (nxt_st.lf)
      LF_OPEN: begin
        nxt_st.drv = '0;
      end
      LF_FWD_ACT: begin
        nxt_st.drv.tip_drive      = 1'b1;
        nxt_st.drv.ring_drive     = 1'b1;
        nxt_st.drv.audio_en       = 1'b1;
        nxt_st.drv.supervision_en = 1'b1;
      end
      LF_REV_ACT: begin
        nxt_st.drv.tip_drive      = 1'b1;
        nxt_st.drv.ring_drive     = 1'b1;
        nxt_st.drv.rev_polarity   = 1'b1;
        nxt_st.drv.audio_en       = 1'b1;
        nxt_st.drv.supervision_en = 1'b1;
      end
      LF_FWD_OHT: begin
        nxt_st.drv.tip_drive      = 1'b1;
        nxt_st.drv.ring_drive     = 1'b1;
        nxt_st.drv.audio_en       = 1'b1;
        nxt_st.drv.supervision_en = 1'b1;
      end
      LF_REV_OHT: begin
        nxt_st.drv.tip_drive      = 1'b1;
        nxt_st.drv.ring_drive     = 1'b1;
        nxt_st.drv.rev_polarity   = 1'b1;
        nxt_st.drv.audio_en       = 1'b1;
        nxt_st.drv.supervision_en = 1'b1;
      end
      LF_TIP_OPEN: begin
        nxt_st.drv.ring_drive     = 1'b1;
        nxt_st.drv.supervision_en = 1'b1;
      end
      LF_RING_OPEN: begin
        nxt_st.drv.tip_drive      = 1'b1;
        nxt_st.drv.rev_polarity   = 1'b1;
        nxt_st.drv.supervision_en = 1'b1;
      end
      LF_RINGING: begin
        nxt_st.drv.tip_drive      = 1'b1;
        nxt_st.drv.ring_drive     = 1'b1;
        nxt_st.drv.supervision_en = 1'b1;
        nxt_st.drv.ringing_en     = 1'b1;
        nxt_st.drv.ring_offset_en = ring_offset_cfg;
      end
    endcase

    // Diagnostics wins over the state code for the leads
    // diagnostics keeps leads high-Z
    if (nxt_st.diag) begin
      nxt_st.drv         = '0;
      nxt_st.drv.diag_en = 1'b1;
    end
    // low power overrides even with auto open off
    if (nxt_st.low_power) begin
      nxt_st.drv = '0;
    end

    // Refresh runs even while tripped, so faults stay visible
    // fixed refresh period
    nxt_st.mon_valid = 1'b0;
    dv = '0;
    di = '0;
    si = '0;
    if (st_ff.mon_cnt == '0) begin
      nxt_st.mon_cnt = CNT_RELOAD;
      dv = (MON_W+1)'(st_ff.lead2.tip_v) - (MON_W+1)'(st_ff.lead2.ring_v);
      di = (MON_W+1)'(st_ff.lead2.tip_i) - (MON_W+1)'(st_ff.lead2.ring_i);
      si = (MON_W+1)'(st_ff.lead2.tip_i) + (MON_W+1)'(st_ff.lead2.ring_i);
      nxt_st.mon.loop_v = dv;
      // Halved currents keep sixteen bits without overflow
      nxt_st.mon.loop_i = di[MON_W:1];
      nxt_st.mon.long_i = si[MON_W:1];
      nxt_st.mon_valid  = 1'b1;
    end else begin
      nxt_st.mon_cnt = st_ff.mon_cnt - CNT_W'(1);
    end

    // Region uses the last refresh, so lags by up to a period
    // dc region from loop current
    imag = mag(st_ff.mon.loop_i);
    if (!is_feed(st_ff.lf) || st_ff.diag || st_ff.low_power) begin
      nxt_st.region = DC_NONE;
    end else if (imag >= cc_i_min) begin
      nxt_st.region = DC_CONST_I;
    end else if (imag <= cv_i_max) begin
      nxt_st.region = DC_CONST_V;
    end else begin
      nxt_st.region = DC_RESISTIVE;
    end

    // Decoded here so the status pins leave a flop directly
    nxt_st.held_open = nxt_st.ctl == CTL_TRIPPED;
    nxt_st.in_osi    = nxt_st.ctl == CTL_OSI;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff            <= '0;
      st_ff.ctl        <= CTL_RUN;
      st_ff.lf         <= LF_RESET;
      st_ff.lf_saved   <= LF_RESET;
      // Counter starts loaded, first refresh one period on
      st_ff.mon_cnt    <= CNT_RELOAD;
      st_ff.region     <= DC_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lf_state        = st_ff.lf;
  assign diag_active     = st_ff.diag;
  assign tripped         = st_ff.held_open;
  assign osi_busy        = st_ff.in_osi;
  assign drive           = st_ff.drv;
  assign low_power       = st_ff.low_power;
  assign alarm_cause     = st_ff.cause;
  assign alarm_pending   = st_ff.pend;
  assign power_alarm_irq = st_ff.irq;
  assign mon             = st_ff.mon;
  assign mon_valid       = st_ff.mon_valid;
  assign dc_region       = st_ff.region;

endmodule // linefeed_ctrl

// File: common/linefeed_pkg.sv
package linefeed_pkg;

  // Linefeed state code, zero is the open state
  typedef logic [2:0] lf_code_t;
  localparam lf_code_t LF_OPEN      = 3'h0;
  localparam lf_code_t LF_FWD_ACT   = 3'h1;
  localparam lf_code_t LF_REV_ACT   = 3'h2;
  localparam lf_code_t LF_FWD_OHT   = 3'h3;
  localparam lf_code_t LF_REV_OHT   = 3'h4;
  localparam lf_code_t LF_TIP_OPEN  = 3'h5;
  localparam lf_code_t LF_RING_OPEN = 3'h6;
  localparam lf_code_t LF_RINGING   = 3'h7;
  localparam lf_code_t LF_RESET     = LF_OPEN;

  // Die temperature thresholds, degrees C
  localparam int       TEMP_W          = 8;
  localparam int       TJ_NORMAL_C     = 145;
  localparam int       TJ_RINGING_C    = 200;

  // Monitor refresh
  localparam int       CLK_HZ          = 125_000_000;
  localparam int       MON_RATE_HZ     = 2000;
  localparam int       MON_PERIOD_CYC  = CLK_HZ / MON_RATE_HZ;
  localparam int       MON_W           = 16;

  // Open switch interval length field
  localparam int       OSI_W           = 16;

  typedef enum logic [1:0] {
    DC_NONE,
    DC_CONST_V,
    DC_CONST_I,
    DC_RESISTIVE
  } dc_region_e;

  typedef struct packed {
    logic power;
    logic foreign;
    logic thermal;
  } fault_s;

  typedef struct packed {
    logic tip_drive;
    logic ring_drive;
    logic rev_polarity;
    logic audio_en;
    logic supervision_en;
    logic ringing_en;
    logic ring_offset_en;
    logic diag_en;
  } drive_s;

  typedef struct packed {
    logic signed [MON_W-1:0] tip_v;
    logic signed [MON_W-1:0] ring_v;
    logic signed [MON_W-1:0] tip_i;
    logic signed [MON_W-1:0] ring_i;
  } lead_s;

  typedef struct packed {
    logic signed [MON_W:0]   loop_v;
    logic signed [MON_W-1:0] loop_i;
    logic signed [MON_W-1:0] long_i;
  } mon_s;

endpackage

// File: dv/linefeed_ctrl_sva.sv
`timescale 1ns/1ps
module linefeed_ctrl_sva #(
  parameter int MON_PERIOD = linefeed_pkg::MON_PERIOD_CYC
) (
  input wire logic                                 clk,
  input wire logic                                 rst,
  input wire linefeed_pkg::lf_code_t               state_sel,
  input wire logic                                 state_wr,
  input wire logic                                 osi_start,
  input wire logic                                 osi_busy,
  input wire logic                                 auto_open_en,
  input wire logic                                 alarm_mask,
  input wire logic                                 power_exceed_pin,
  input wire logic                                 foreign_fault_pin,
  input wire logic [linefeed_pkg::TEMP_W-1:0]      die_temp_pin,
  input wire linefeed_pkg::lf_code_t               lf_state,
  input wire logic                                 diag_active,
  input wire logic                                 tripped,
  input wire linefeed_pkg::drive_s                 drive,
  input wire logic                                 low_power,
  input wire linefeed_pkg::fault_s                 alarm_cause,
  input wire logic                                 alarm_pending,
  input wire logic                                 power_alarm_irq,
  input wire logic                                 mon_valid
);
  import linefeed_pkg::*;
  int unsigned gap_ff;
  logic        seen_ff;
  // Gap counter is only trusted after the first refresh
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_ff  <= 0;
      seen_ff <= 1'b0;
    end else if (mon_valid) begin
      gap_ff  <= 0;
      seen_ff <= 1'b1;
    end else begin
      gap_ff  <= gap_ff + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Faults seen two edges late by the synchronisers
  a_write_loads_state: assert property (
    state_wr && !tripped && !osi_busy && !osi_start &&
    !$past(power_exceed_pin, 2) && !$past(foreign_fault_pin, 2) &&
    $past(die_temp_pin, 2) <= TJ_NORMAL_C |=> lf_state == $past(state_sel))
    else $error("state write not loaded");
  a_power_trip_open: assert property (
    power_exceed_pin && auto_open_en |-> ##3 (tripped &&
    lf_state == LF_OPEN && alarm_cause.power && alarm_pending))
    else $error("power fault did not open line");
  a_irq_masked_off: assert property (
    alarm_mask && $past(alarm_mask) |-> !power_alarm_irq)
    else $error("masked alarm raised irq");
  a_irq_follows_pend: assert property (
    alarm_pending && $past(alarm_pending) && !alarm_mask &&
    !$past(alarm_mask) |-> power_alarm_irq)
    else $error("pending alarm without irq");
  a_open_quiet: assert property (
    lf_state == LF_OPEN && !diag_active |-> drive == '0)
    else $error("open state drives line");
  a_low_power_off: assert property (
    low_power |-> drive == '0)
    else $error("low power still drives");
  a_tip_open_feed: assert property (
    lf_state == LF_TIP_OPEN && !diag_active && !low_power |->
    drive.ring_drive && !drive.tip_drive)
    else $error("tip open feed wrong");
  a_reverse_feed: assert property (
    (lf_state == LF_REV_ACT || lf_state == LF_REV_OHT) && !diag_active &&
    !low_power |-> drive.rev_polarity && drive.audio_en)
    else $error("reverse feed wrong");
  a_mon_period: assert property (
    mon_valid && seen_ff |-> gap_ff == MON_PERIOD - 1)
    else $error("monitor refresh period wrong");
endmodule // linefeed_ctrl_sva

bind linefeed_ctrl linefeed_ctrl_sva #(.MON_PERIOD(MON_PERIOD)) u_sva (
  .clk(clk), .rst(rst), .state_sel(state_sel), .state_wr(state_wr),
  .osi_start(osi_start), .osi_busy(osi_busy), .auto_open_en(auto_open_en),
  .alarm_mask(alarm_mask), .power_exceed_pin(power_exceed_pin),
  .foreign_fault_pin(foreign_fault_pin), .die_temp_pin(die_temp_pin),
  .lf_state(lf_state), .diag_active(diag_active), .tripped(tripped),
  .drive(drive), .low_power(low_power), .alarm_cause(alarm_cause),
  .alarm_pending(alarm_pending), .power_alarm_irq(power_alarm_irq),
  .mon_valid(mon_valid));

// File: dv/linefeed_ctrl_tb.sv
`timescale 1ns/1ps
module linefeed_ctrl_tb;
  import linefeed_pkg::*;
  localparam int          MON_P = 20;
  // Feed bits tip, ring, reverse per code, code 7 at the top
  localparam logic [23:0] FEED  = 24'hD57DF0;
  logic              clk = 1'b0;
  logic              rst, state_wr, diag_sel, ring_offset_cfg, auto_open_en;
  logic              alarm_mask, alarm_clr, osi_start;
  logic              power_exceed_pin, foreign_fault_pin;
  logic [OSI_W-1:0]  osi_cycles;
  lf_code_t          state_sel, lf_state;
  fault_s            cause_clr, alarm_cause;
  logic [TEMP_W-1:0] die_temp_pin;
  lead_s             lead_pin;
  drive_s            drive;
  mon_s              mon;
  dc_region_e        dc_region;
  logic              diag_active, tripped, osi_busy, low_power;
  logic              alarm_pending, power_alarm_irq, mon_valid;
  int                error_cnt = 0, comparisons = 0, cyc = 0;
  linefeed_ctrl #(.MON_PERIOD(MON_P)) uut (
    .clk(clk), .rst(rst), .state_sel(state_sel), .diag_sel(diag_sel),
    .state_wr(state_wr), .ring_offset_cfg(ring_offset_cfg),
    .auto_open_en(auto_open_en), .alarm_mask(alarm_mask),
    .alarm_clr(alarm_clr), .cause_clr(cause_clr), .osi_start(osi_start),
    .osi_cycles(osi_cycles), .power_exceed_pin(power_exceed_pin),
    .foreign_fault_pin(foreign_fault_pin), .die_temp_pin(die_temp_pin),
    .lead_pin(lead_pin), .cv_i_max(16'h0100), .cc_i_min(16'h0200),
    .lf_state(lf_state), .diag_active(diag_active), .tripped(tripped),
    .osi_busy(osi_busy), .drive(drive), .low_power(low_power),
    .alarm_cause(alarm_cause), .alarm_pending(alarm_pending),
    .power_alarm_irq(power_alarm_irq), .mon(mon), .mon_valid(mon_valid),
    .dc_region(dc_region));
  always #4 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [63:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic wr(input lf_code_t c, input logic d);
    state_sel = c;
    diag_sel  = d;
    state_wr  = 1'b1;
    tick(1);
    state_wr  = 1'b0;
    tick(1);
  endtask
  // Synced pins need two edges to fall before a write counts
  task automatic clear();
    power_exceed_pin  = 1'b0;
    foreign_fault_pin = 1'b0;
    die_temp_pin      = 8'h19;
    tick(4);
    alarm_clr = 1'b1;
    cause_clr = '1;
    tick(1);
    alarm_clr = 1'b0;
    cause_clr = '0;
    tick(1);
    chk("pending", alarm_pending, 1'b0);
    wr(LF_FWD_ACT, 1'b0);
  endtask
  task automatic t_states();
    ring_offset_cfg = 1'b1;
    for (int c = 1; c < 8; c++) begin
      wr(lf_code_t'(c), 1'b0);
      chk("code", lf_state, c);
      chk("feed", {drive.tip_drive, drive.ring_drive, drive.rev_polarity},
          FEED[3*c +: 3]);
      if (c < 5) chk("audio", drive.audio_en, 1'b1);
      else if (c < 7) chk("superv", drive.supervision_en, 1'b1);
      else chk("ring", {drive.ringing_en, drive.ring_offset_en}, 2'b11);
    end
    ring_offset_cfg = 1'b0;
    wr(LF_RINGING, 1'b0);
    chk("offset", drive.ring_offset_en, 1'b0);
    wr(LF_OPEN, 1'b0);
    chk("open", drive, 8'h00);
    wr(LF_FWD_ACT, 1'b1);
    chk("diag", {diag_active, drive}, 9'h101);
    wr(LF_FWD_ACT, 1'b0);
  endtask
  // open switch interval, writes refused meanwhile
  task automatic t_osi();
    osi_cycles = 16'h0005;
    osi_start  = 1'b1;
    tick(1);
    osi_start  = 1'b0;
    chk("osi", {osi_busy, lf_state}, 4'h8);
    wr(LF_REV_ACT, 1'b0);
    chk("osi_wr", {osi_busy, lf_state}, 4'h8);
    tick(2);
    chk("osi_hold", osi_busy, 1'b1);
    tick(1);
    chk("osi_end", {osi_busy, lf_state}, {1'b0, LF_FWD_ACT});
  endtask
  task automatic t_faults();
    for (int s = 0; s < 3; s++) begin
      power_exceed_pin  = (s == 0);
      foreign_fault_pin = (s == 1);
      die_temp_pin      = (s == 2) ? 8'hA0 : 8'h19;
      tick(4);
      chk("trip", {tripped, lf_state}, 4'h8);
      chk("cause", alarm_cause, 3'b100 >> s);
      chk("irq", power_alarm_irq, 1'b1);
      wr(LF_FWD_ACT, 1'b0);
      chk("refused", lf_state, LF_OPEN);
      clear();
      chk("rearm", lf_state, LF_FWD_ACT);
    end
  endtask
  task automatic t_mask();
    auto_open_en     = 1'b0;
    alarm_mask       = 1'b1;
    power_exceed_pin = 1'b1;
    tick(4);
    chk("masked", {alarm_pending, power_alarm_irq}, 2'b10);
    chk("stay", lf_state, LF_FWD_ACT);
    alarm_mask = 1'b0;
    tick(2);
    chk("unmask", power_alarm_irq, 1'b1);
    clear();
  endtask
  task automatic t_thermal();
    lf_code_t          st [4] = '{LF_RINGING, LF_RINGING,
                                   LF_FWD_ACT, LF_FWD_ACT};
    logic [TEMP_W-1:0] tp [4] = '{8'hC8, 8'hC9, 8'h91, 8'h92};
    for (int i = 0; i < 4; i++) begin
      wr(st[i], 1'b0);
      die_temp_pin = tp[i];
      tick(4);
      chk("low_power", low_power, i % 2);
      die_temp_pin = 8'h19;
      tick(4);
    end
    clear();
    auto_open_en = 1'b1;
  endtask
  task automatic wait_mon();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (mon_valid !== 1'b1 && n < MON_P + 1);
    chk("mon_valid", mon_valid, 1'b1);
  endtask
  task automatic t_mon(input logic [15:0] ti, input dc_region_e rg);
    lead_pin = '{tip_v: 16'h0100, ring_v: 16'hFF00, tip_i: ti, ring_i: -ti};
    wait_mon();
    wait_mon();
    chk("mon", mon, {17'h00200, ti, 16'h0000});
    tick(2);
    chk("region", dc_region, rg);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {state_wr, diag_sel, ring_offset_cfg, alarm_mask, alarm_clr} = '0;
    osi_start    = 1'b0;
    osi_cycles   = '0;
    {power_exceed_pin, foreign_fault_pin} = '0;
    auto_open_en = 1'b1;
    state_sel    = LF_OPEN;
    cause_clr    = '0;
    die_temp_pin = 8'h19;
    lead_pin     = '0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(1);
    chk("reset", {lf_state, drive, dc_region}, 13'h0000);
    t_states();
    t_osi();
    t_faults();
    t_mask();
    t_thermal();
    t_mon(16'h0040, DC_CONST_V);
    t_mon(16'h0180, DC_RESISTIVE);
    t_mon(16'h0300, DC_CONST_I);
    wr(LF_OPEN, 1'b0);
    wait_mon();
    tick(2);
    chk("region", dc_region, DC_NONE);
    tally_and_finish();
  end
endmodule // linefeed_ctrl_tb
